// ---- include/rst_ctrl_pkg.sv ----
package rst_ctrl_pkg;

	// ========================================
	// register map (byte addresses)
	localparam int         ADDR_W          = 8;
	localparam int         DATA_W          = 32;
	localparam logic [7:0] OFS_CAUSE       = 8'h00;
	localparam logic [7:0] OFS_BROWN_CFG   = 8'h04;
	localparam logic [7:0] OFS_OSC_CTRL    = 8'h08;
	localparam logic [7:0] OFS_PRST0       = 8'h0C;
	localparam logic [7:0] OFS_PRST1       = 8'h10;
	localparam logic [7:0] OFS_PRST2       = 8'h14;
	localparam logic [7:0] OFS_SYS_REQ     = 8'h18;
	localparam logic [7:0] OFS_WDT_LOAD    = 8'h20;
	localparam logic [7:0] OFS_WDT_CTRL    = 8'h24;
	localparam logic [7:0] OFS_WDT_VALUE   = 8'h28;
	localparam logic [7:0] OFS_WDT_CLEAR   = 8'h2C;
	localparam logic [7:0] OFS_STATUS      = 8'h30;

	// ========================================
	// field positions
	localparam int CAUSE_EXT       = 0;
	localparam int CAUSE_POR       = 1;
	localparam int CAUSE_BROWN     = 2;
	localparam int CAUSE_SW        = 3;
	localparam int CAUSE_WDT       = 4;
	localparam int CAUSE_OSC       = 5;
	localparam int CAUSE_W         = 6;
	localparam int BROWN_RST_EN    = 1;
	localparam int OSC_CHECK_EN    = 0;
	localparam int SYS_REQ_BIT     = 0;
	localparam int WDT_INT_EN      = 0;
	localparam int WDT_RST_EN      = 1;
	localparam int STAT_RUN        = 0;
	localparam int STAT_BROWN      = 1;
	localparam int STAT_WDT_INT    = 2;
	localparam int STAT_NMI        = 3;
	localparam int PRST_REGS       = 3;

	// ========================================
	// reset values and vectors
	localparam logic [31:0] WDT_LOAD_RST   = 32'hFFFF_FFFF;
	localparam logic [31:0] VEC_SP_ADDR    = 32'h0000_0000;
	localparam logic [31:0] VEC_RESET_ADDR = 32'h0000_0004;
	localparam logic [31:0] VEC_NMI_ADDR   = 32'h0000_0008;
	localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

	// ========================================
	// timing
	localparam int CLK_PERIOD_NS   = 5;
	localparam int PULSE_HOLD_NS   = 20;
	localparam int PULSE_CYCLES    = (PULSE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES     = 3;
	localparam int SRC_W           = 4;

	// ========================================
	// carriers
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	typedef struct packed {
		logic [31:0] addr;
		logic        req;
	} fetch_req_t;

	typedef enum {BOOT_HOLD, BOOT_SP, BOOT_PC, BOOT_INSN, BOOT_RUN} boot_state_t;

endpackage

// ---- src/reset_control_and_cause.sv ----
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module reset_control_and_cause
	import rst_ctrl_pkg::*;
#(
	parameter int PERIPH_W = 32,
	parameter int DOMAINS  = 2
)(
	input  wire logic                              clk_sys,
	input  wire logic                              sys_rst,
	input  wire bus_req_t                          busReq,
	output logic [DATA_W-1:0]                      rdData,
	input  wire logic                              extRstN,
	input  wire logic                              porIn,
	input  wire logic                              brownoutDetect,
	input  wire logic                              mainOscFail,
	input  wire logic                              systemResetRequestBit,
	output logic                                   internalRst,
	output logic                                   tapRst,
	output logic [DOMAINS-1:0][PRST_REGS*PERIPH_W-1:0] periphRst,
	output logic                                   brownoutIrq,
	output logic                                   wdtIrq,
	output fetch_req_t                             fetch,
	input  wire logic                              fetchAck,
	input  wire logic [31:0]                       fetchData,
	output logic [31:0]                            bootSp,
	output logic [31:0]                            bootPc,
	output logic [31:0]                            bootInsn,
	output logic                                   bootNmi,
	output logic                                   cpuRun
);

	// ========================================
	// input synchronisers
	logic [SRC_W-1:0] srcMeta_r;
	logic [SRC_W-1:0] srcMid_r;
	logic [SRC_W-1:0] srcLast_r;
	logic [SRC_W-1:0] srcStable_r;
	logic             extS;
	logic             porS;
	logic             brownS;
	logic             oscFailS;
	logic             oscFailPrev_r;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge clk_sys)
	begin
		srcMeta_r <= {mainOscFail, brownoutDetect, porIn, ~extRstN};
		srcMid_r  <= srcMeta_r;
		srcLast_r <= srcMid_r;
		if (sys_rst)
		begin
			srcStable_r    <= '0;
			srcStable_r[1] <= 1'b1; // power-up assumes power-on still active
		end
		else
		begin
			for (int i = 0; i < SRC_W; i++)
				if (srcMid_r[i] == srcLast_r[i])
					srcStable_r[i] <= srcLast_r[i];
		end
	end

	assign extS     = srcStable_r[0];
	assign porS     = srcStable_r[1];
	assign brownS   = srcStable_r[2];
	assign oscFailS = srcStable_r[3];

	// ========================================
	// configuration registers
	logic                            porDone_r;
	logic                            brownoutResetEnableBit_r;
	logic                            oscCheckEnable_r;
	logic [PRST_REGS*PERIPH_W-1:0]   peripheralResetCtrl_r;
	logic                            porG;
	logic                            wrHit;

	assign wrHit = busReq.wr;

	// power-on source only counts before its first release
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			porDone_r <= 1'b0;
		else if (!porS)
			porDone_r <= 1'b1;
	end

	assign porG = porS & ~porDone_r;

	// brown-out and oscillator check enables, cleared at power-up
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || porG)
		begin
			brownoutResetEnableBit_r <= 1'b0;
			oscCheckEnable_r         <= 1'b0;
		end
		else if (wrHit && busReq.addr == OFS_BROWN_CFG)
			brownoutResetEnableBit_r <= busReq.wdata[BROWN_RST_EN];
		else if (wrHit && busReq.addr == OFS_OSC_CTRL)
			oscCheckEnable_r <= busReq.wdata[OSC_CHECK_EN];
	end

	// ========================================
	// reset merging and stretch
	logic                 rstHold_r;
	logic [7:0]           stretch_r;
	logic                 swEvt;
	logic                 wdtFire;
	logic                 oscEvt;
	logic                 brownRst;
	logic                 pulseEvt;

	assign swEvt    = systemResetRequestBit
		| (wrHit && busReq.addr == OFS_SYS_REQ && busReq.wdata[SYS_REQ_BIT]);
	assign oscEvt   = oscCheckEnable_r & oscFailS & ~oscFailPrev_r;
	assign brownRst = brownS & brownoutResetEnableBit_r;
	assign pulseEvt = swEvt | wdtFire | oscEvt;

	// pulse sources hold the reset for a fixed stretch
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			stretch_r     <= '0;
			oscFailPrev_r <= 1'b0;
		end
		else
		begin
			oscFailPrev_r <= oscFailS;
			if (pulseEvt)
				stretch_r <= 8'(PULSE_CYCLES);
			else if (stretch_r != '0)
				stretch_r <= stretch_r - 8'h01;
		end
	end

	// level sources hold the reset while active; release is clocked
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			rstHold_r <= 1'b1;
		else
			rstHold_r <= extS | porG | brownRst | pulseEvt | (stretch_r > 8'h01);
	end

	// raw pin and power-on assert at once, release waits for clock
	assign internalRst = rstHold_r | ~extRstN | (porIn & ~porDone_r);
	assign tapRst      = sys_rst | porG;
	assign brownoutIrq = brownS & ~brownoutResetEnableBit_r;

	// ========================================
	// reset cause record
	logic [CAUSE_W-1:0] resetCauseRecord_r;
	logic [CAUSE_W-1:0] causeSet;
	logic [CAUSE_W-1:0] causeClr;

	// one bit per source; write one clears, a new event wins
	always_comb
	begin
		causeSet              = '0;
		causeSet[CAUSE_EXT]   = extS;
		causeSet[CAUSE_BROWN] = brownRst;
		causeSet[CAUSE_SW]    = swEvt;
		causeSet[CAUSE_WDT]   = wdtFire;
		causeSet[CAUSE_OSC]   = oscEvt;
		causeClr              = '0;
		if (wrHit && busReq.addr == OFS_CAUSE)
			causeClr = busReq.wdata[CAUSE_W-1:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			resetCauseRecord_r <= '0;
		else if (porG)
			resetCauseRecord_r <= CAUSE_W'(1 << CAUSE_POR);
		else
			resetCauseRecord_r <= (resetCauseRecord_r & ~causeClr) | causeSet;
	end

	// ========================================
	// peripheral software reset
	// bit n of each register is peripheral n, same place as its clock gate
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || rstHold_r)
			peripheralResetCtrl_r <= '0;
		else if (wrHit)
		begin
			for (int r = 0; r < PRST_REGS; r++)
				if (busReq.addr == OFS_PRST0 + 8'(4 * r))
					peripheralResetCtrl_r[r*PERIPH_W +: PERIPH_W]
						<= busReq.wdata[PERIPH_W-1:0];
		end
	end

	// held while set, released by the clear; same reset in every domain
	always_comb
	begin
		for (int d = 0; d < DOMAINS; d++)
			periphRst[d] = peripheralResetCtrl_r | {(PRST_REGS*PERIPH_W){rstHold_r}};
	end

	// ========================================
	// watchdog
	logic [31:0] watchdogReloadValue_r;
	logic [31:0] wdtCount_r;
	logic        wdtIntEn_r;
	logic        wdtRstEn_r;
	logic        wdtRaw_r;
	logic        wdtZero;

	assign wdtZero = wdtIntEn_r && wdtCount_r == ZERO_WORD;
	assign wdtFire = wdtZero & wdtRaw_r & wdtRstEn_r;
	assign wdtIrq  = wdtRaw_r & wdtIntEn_r;

	// down counter, reloaded at each time-out
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || rstHold_r)
		begin
			watchdogReloadValue_r <= WDT_LOAD_RST;
			wdtCount_r            <= WDT_LOAD_RST;
		end
		else if (wrHit && busReq.addr == OFS_WDT_LOAD)
		begin
			watchdogReloadValue_r <= busReq.wdata;
			wdtCount_r            <= busReq.wdata;
		end
		else if (wdtZero)
			wdtCount_r <= watchdogReloadValue_r;
		else if (wdtIntEn_r)
			wdtCount_r <= wdtCount_r - 32'h0000_0001;
	end

	// control bits
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || rstHold_r)
		begin
			wdtIntEn_r <= 1'b0;
			wdtRstEn_r <= 1'b0;
		end
		else if (wrHit && busReq.addr == OFS_WDT_CTRL)
		begin
			wdtIntEn_r <= busReq.wdata[WDT_INT_EN];
			wdtRstEn_r <= busReq.wdata[WDT_RST_EN];
		end
	end

	// first time-out flag; time-out wins over a clear
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || rstHold_r)
			wdtRaw_r <= 1'b0;
		else if (wdtZero)
			wdtRaw_r <= 1'b1;
		else if (wrHit && busReq.addr == OFS_WDT_CLEAR)
			wdtRaw_r <= 1'b0;
	end

	// ========================================
	// start-up fetch sequence
	boot_state_t bootState_r;
	logic [31:0] fetchAddr_r;
	logic [31:0] bootSp_r;
	logic [31:0] bootPc_r;
	logic [31:0] bootInsn_r;
	logic        bootNmi_r;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || rstHold_r)
		begin
			bootState_r <= BOOT_HOLD;
			fetchAddr_r <= VEC_SP_ADDR;
			bootNmi_r   <= 1'b0;
		end
		else
		begin
			unique case (bootState_r)
				BOOT_HOLD:
					bootState_r <= BOOT_SP;
				BOOT_SP:
					if (fetchAck)
					begin
						bootState_r <= BOOT_PC;
						bootNmi_r   <= resetCauseRecord_r[CAUSE_OSC];
						fetchAddr_r <= resetCauseRecord_r[CAUSE_OSC]
							? VEC_NMI_ADDR : VEC_RESET_ADDR;
					end
				BOOT_PC:
					if (fetchAck)
					begin
						bootState_r <= BOOT_INSN;
						fetchAddr_r <= fetchData;
					end
				BOOT_INSN:
					if (fetchAck)
						bootState_r <= BOOT_RUN;
				BOOT_RUN:
					bootState_r <= BOOT_RUN;
			endcase
		end
	end

	// captured vector words
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			bootSp_r   <= ZERO_WORD;
			bootPc_r   <= ZERO_WORD;
			bootInsn_r <= ZERO_WORD;
		end
		else if (fetchAck)
		begin
			if (bootState_r == BOOT_SP)
				bootSp_r <= fetchData;
			if (bootState_r == BOOT_PC)
				bootPc_r <= fetchData;
			if (bootState_r == BOOT_INSN)
				bootInsn_r <= fetchData;
		end
	end

	assign fetch.req  = bootState_r inside {BOOT_SP, BOOT_PC, BOOT_INSN};
	assign fetch.addr = fetchAddr_r;
	assign bootSp     = bootSp_r;
	assign bootPc     = bootPc_r;
	assign bootInsn   = bootInsn_r;
	assign bootNmi    = bootNmi_r;
	assign cpuRun     = bootState_r == BOOT_RUN;

	// ========================================
	// register read port, data in the cycle after the strobe
	logic [DATA_W-1:0] rdData_r;
	logic [DATA_W-1:0] rdMux;

	always_comb
	begin
		rdMux = ZERO_WORD;
		unique case (busReq.addr)
			OFS_CAUSE:     rdMux[CAUSE_W-1:0] = resetCauseRecord_r;
			OFS_BROWN_CFG: rdMux[BROWN_RST_EN] = brownoutResetEnableBit_r;
			OFS_OSC_CTRL:  rdMux[OSC_CHECK_EN] = oscCheckEnable_r;
			OFS_PRST0:     rdMux[PERIPH_W-1:0] = peripheralResetCtrl_r[0 +: PERIPH_W];
			OFS_PRST1:     rdMux[PERIPH_W-1:0] = peripheralResetCtrl_r[PERIPH_W +: PERIPH_W];
			OFS_PRST2:     rdMux[PERIPH_W-1:0] = peripheralResetCtrl_r[2*PERIPH_W +: PERIPH_W];
			OFS_WDT_LOAD:  rdMux = watchdogReloadValue_r;
			OFS_WDT_CTRL:  rdMux[WDT_RST_EN:WDT_INT_EN] = {wdtRstEn_r, wdtIntEn_r};
			OFS_WDT_VALUE: rdMux = wdtCount_r;
			OFS_STATUS:
			begin
				rdMux[STAT_RUN]     = cpuRun;
				rdMux[STAT_BROWN]   = brownS;
				rdMux[STAT_WDT_INT] = wdtRaw_r;
				rdMux[STAT_NMI]     = bootNmi_r;
			end
			default:       rdMux = ZERO_WORD;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !busReq.rd)
			rdData_r <= ZERO_WORD;
		else
			rdData_r <= rdMux;
	end

	assign rdData = rdData_r;

	// ========================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_held_stretch;
		rstHold_r [*4];
	endsequence

	sequence s_boot_sp;
		fetch.req && fetch.addr == VEC_SP_ADDR;
	endsequence

	a_por_clears_cause: assert property (porG |=> resetCauseRecord_r == CAUSE_W'(1 << CAUSE_POR))
		else $error("power-on did not leave only the power-on cause");

	a_cause_sticky: assert property (!porG && !(wrHit && busReq.addr == OFS_CAUSE)
		|=> (resetCauseRecord_r & $past(resetCauseRecord_r)) == $past(resetCauseRecord_r))
		else $error("cause bit lost without clear");

	a_pin_holds_reset: assert property (extS && !porG
		|=> rstHold_r && resetCauseRecord_r[CAUSE_EXT])
		else $error("pin reset not held or not recorded");

	a_tap_spared_pin: assert property (extS && !porG |-> !tapRst)
		else $error("test port reset by pin");

	a_brown_gated: assert property (brownS && !brownoutResetEnableBit_r && !extS && !porG
		&& stretch_r == '0 && !pulseEvt |-> brownoutIrq ##1 !rstHold_r)
		else $error("disabled brown-out reset the system");

	a_sw_stretch: assert property ($rose(swEvt) && !rstHold_r |=> s_held_stretch)
		else $error("system request reset too short");

	a_boot_first_sp: assert property ($fell(rstHold_r) |=> s_boot_sp)
		else $error("start-up did not fetch stack pointer first");

	a_boot_order: assert property (bootState_r == BOOT_PC && fetchAck |=> bootState_r == BOOT_INSN
		&& fetch.addr == $past(fetchData))
		else $error("instruction fetch not from loaded counter");

	a_wdt_reload: assert property (wdtZero && !wdtRaw_r |=> wdtRaw_r
		&& wdtCount_r == $past(watchdogReloadValue_r))
		else $error("watchdog did not reload on first time-out");

	a_wdt_reset: assert property (wdtFire |=> rstHold_r && resetCauseRecord_r[CAUSE_WDT])
		else $error("second time-out did not reset");

	a_periph_bit: assert property (peripheralResetCtrl_r[0] |-> periphRst[DOMAINS-1][0])
		else $error("peripheral reset bit not applied");

	a_nmi_entry: assert property (bootState_r == BOOT_SP && fetchAck
		&& resetCauseRecord_r[CAUSE_OSC] |=> bootNmi && fetch.addr == VEC_NMI_ADDR)
		else $error("oscillator failure start-up missed handler");

endmodule

// ---- verification/boot_mem_model.sv ----
`timescale 1ns/1ps
// ========================================
// boot memory answering the start-up fetches
module boot_mem_model
	import rst_ctrl_pkg::*;
#(
	parameter logic [31:0] SP_WORD  = 32'h2000_0400,
	parameter logic [31:0] PC_WORD  = 32'h0000_0100,
	parameter logic [31:0] NMI_WORD = 32'h0000_0200
)(
	input  wire logic       clk_sys,
	input  wire fetch_req_t fetch,
	input  wire logic [2:0] lag,
	output logic            fetchAck,
	output logic [31:0]     fetchData
);
	logic [2:0] waitCnt;

	// vectors, any other word is its address inverted
	function automatic logic [31:0] word_at(input logic [31:0] a);
		case (a)
			VEC_SP_ADDR:    return SP_WORD;
			VEC_RESET_ADDR: return PC_WORD;
			VEC_NMI_ADDR:   return NMI_WORD;
			default:        return ~a;
		endcase
	endfunction

	initial
	begin
		fetchAck = 1'h0;
		fetchData = 32'h0000_0000;
		waitCnt = 3'h0;
	end

	// one-cycle ack after lag cycles; data toggles when not valid
	always @(posedge clk_sys)
	begin
		if (fetchAck)
		begin
			fetchAck <= 1'h0;
			fetchData <= ~fetchData;
			waitCnt <= 3'h0;
		end
		else if (fetch.req && waitCnt >= lag)
		begin
			fetchAck <= 1'h1;
			fetchData <= word_at(fetch.addr);
		end
		else
		begin
			fetchData <= ~fetchData;
			waitCnt <= fetch.req ? waitCnt + 3'h1 : 3'h0;
		end
	end
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import rst_ctrl_pkg::*;
;
	localparam logic [31:0] SP_W  = 32'h2000_0400;
	localparam logic [31:0] PC_W  = 32'h0000_0100;
	localparam logic [31:0] NMI_W = 32'h0000_0200;

	logic                    clk_sys;
	logic                    sys_rst;
	bus_req_t                busReq;
	logic [31:0]             rdData;
	logic                    extRstN;
	logic                    porIn;
	logic                    brownoutDetect;
	logic                    mainOscFail;
	logic                    systemResetRequestBit;
	logic                    internalRst;
	logic                    tapRst;
	logic [1:0][95:0]        periphRst;
	logic                    brownoutIrq;
	logic                    wdtIrq;
	fetch_req_t              fetch;
	logic                    fetchAck;
	logic [31:0]             fetchData;
	logic [31:0]             bootSp;
	logic [31:0]             bootPc;
	logic [31:0]             bootInsn;
	logic                    bootNmi;
	logic                    cpuRun;
	logic [2:0]              lag;
	logic                    rdSeen;
	logic [31:0]             expQ[$];
	logic [31:0]             lfsrVal;
	logic [31:0]             expCause;
	int                      miscompares;
	int                      checks;
	int                      cycles;
	int                      n;

	reset_control_and_cause #(.PERIPH_W(32), .DOMAINS(2)) uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData),
		.extRstN(extRstN), .porIn(porIn), .brownoutDetect(brownoutDetect),
		.mainOscFail(mainOscFail), .systemResetRequestBit(systemResetRequestBit),
		.internalRst(internalRst), .tapRst(tapRst), .periphRst(periphRst),
		.brownoutIrq(brownoutIrq), .wdtIrq(wdtIrq), .fetch(fetch), .fetchAck(fetchAck),
		.fetchData(fetchData), .bootSp(bootSp), .bootPc(bootPc), .bootInsn(bootInsn),
		.bootNmi(bootNmi), .cpuRun(cpuRun));

	boot_mem_model #(.SP_WORD(SP_W), .PC_WORD(PC_W), .NMI_WORD(NMI_W)) mem (
		.clk_sys(clk_sys), .fetch(fetch), .lag(lag), .fetchAck(fetchAck),
		.fetchData(fetchData));

	// ========================================
	// helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkb(input string what, input logic exp, input logic got);
		chk(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		busReq.addr <= a;
		busReq.wdata <= d;
		busReq.wr <= 1'h1;
		@(posedge clk_sys);
		busReq.wr <= 1'h0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		busReq.addr <= a;
		busReq.rd <= 1'h1;
		expQ.push_back(exp);
		@(posedge clk_sys);
		busReq.rd <= 1'h0;
	endtask

	task automatic wait_boot;
		n = 0;
		while (cpuRun !== 1'h1 && n < 300)
		begin
			@(posedge clk_sys);
			n++;
		end
		chkb("cpuRun", 1'h1, cpuRun);
	endtask

	task automatic check_boot(input logic [31:0] pc, input logic nmi);
		chk("bootSp", SP_W, bootSp);
		chk("bootPc", pc, bootPc);
		chk("bootInsn", ~pc, bootInsn);
		chkb("bootNmi", nmi, bootNmi);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ========================================
	// clock, timeout and read-data monitor
	initial
	begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		rdSeen <= busReq.rd;
		if (cycles == 5000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	// read data stands only in the cycle after the strobe
	always @(negedge clk_sys)
		if (rdSeen)
			chk("rdData", expQ.pop_front(), rdData);

	// ========================================
	// scenarios
	initial
	begin
		sys_rst = 1'h1;
		porIn = 1'h1;
		extRstN = 1'h0;
		brownoutDetect = 1'h0;
		mainOscFail = 1'h0;
		systemResetRequestBit = 1'h0;
		busReq = '0;
		lag = 3'h2;
		rdSeen = 1'h0;
		lfsrVal = 32'h0000_004F;
		miscompares = 0;
		checks = 0;
		cycles = 0;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'h0;
		extRstN <= 1'h1;
		repeat (8) @(posedge clk_sys);
		#1 chkb("internalRst", 1'h1, internalRst);
		chkb("tapRst", 1'h1, tapRst);
		@(posedge clk_sys);
		porIn <= 1'h0;
		wait_boot();
		check_boot(PC_W, 1'h0);
		reg_rd(OFS_CAUSE, 32'h0000_0002);
		@(posedge clk_sys);
		porIn <= 1'h1;
		repeat (8) @(posedge clk_sys);
		#1 chkb("internalRst", 1'h0, internalRst);
		@(posedge clk_sys);
		porIn <= 1'h0;
		reg_wr(OFS_CAUSE, 32'h0000_0002);
		reg_rd(OFS_CAUSE, 32'h0000_0000);
		reg_rd(8'h3C, 32'h0000_0000);
		$display("test power-on done");

		reg_rd(OFS_BROWN_CFG, 32'h0000_0000);
		@(posedge clk_sys);
		brownoutDetect <= 1'h1;
		repeat (6) @(posedge clk_sys);
		#1 chkb("brownoutIrq", 1'h1, brownoutIrq);
		chkb("internalRst", 1'h0, internalRst);
		@(posedge clk_sys);
		brownoutDetect <= 1'h0;
		repeat (6) @(posedge clk_sys);
		reg_wr(OFS_BROWN_CFG, 32'h0000_0002);
		reg_rd(OFS_BROWN_CFG, 32'h0000_0002);
		@(posedge clk_sys);
		brownoutDetect <= 1'h1;
		repeat (20) @(posedge clk_sys);
		#1 chkb("internalRst", 1'h1, internalRst);
		@(posedge clk_sys);
		brownoutDetect <= 1'h0;
		lag <= 3'h0;
		wait_boot();
		reg_wr(OFS_BROWN_CFG, 32'h0000_0000);
		expCause = 32'h0000_0004;
		reg_rd(OFS_CAUSE, expCause);
		$display("test brown-out done");

		@(posedge clk_sys);
		systemResetRequestBit <= 1'h1;
		@(posedge clk_sys);
		systemResetRequestBit <= 1'h0;
		n = 0;
		repeat (10)
		begin
			#1 if (internalRst === 1'h1) n++;
			@(posedge clk_sys);
		end
		chk("pulse hold", PULSE_CYCLES, n);
		wait_boot();
		check_boot(PC_W, 1'h0);
		reg_wr(OFS_SYS_REQ, 32'h0000_0001);
		#1 chkb("internalRst", 1'h1, internalRst);
		@(posedge clk_sys);
		#1 chkb("cpuRun", 1'h0, cpuRun);
		wait_boot();
		expCause = expCause | 32'h0000_0008;
		reg_rd(OFS_CAUSE, expCause);
		$display("test system request done");

		@(posedge clk_sys);
		extRstN <= 1'h0;
		#1 chkb("internalRst", 1'h1, internalRst);
		chkb("tapRst", 1'h0, tapRst);
		repeat (5) @(posedge clk_sys);
		extRstN <= 1'h1;
		@(posedge clk_sys);
		#1 chkb("internalRst", 1'h1, internalRst);
		wait_boot();
		expCause = expCause | 32'h0000_0001;
		reg_rd(OFS_CAUSE, expCause);
		$display("test pin reset done");

		for (int r = 0; r < 3; r++)
		begin
			lfsrVal = lfsr_next(lfsrVal);
			reg_wr(8'(OFS_PRST0 + 4 * r), lfsrVal);
			for (int d = 0; d < 2; d++)
				#1 chk("periphRst", lfsrVal, periphRst[d][r*32 +: 32]);
			reg_rd(8'(OFS_PRST0 + 4 * r), lfsrVal);
			reg_wr(8'(OFS_PRST0 + 4 * r), 32'h0000_0000);
			#1 chk("periphRst", 32'h0000_0000, periphRst[1][r*32 +: 32]);
		end
		$display("test peripheral reset done");

		reg_wr(OFS_WDT_LOAD, 32'h0000_0010);
		reg_wr(OFS_WDT_CTRL, 32'h0000_0001);
		n = 0;
		while (wdtIrq !== 1'h1 && n < 60)
		begin
			@(posedge clk_sys);
			n++;
		end
		chkb("wdtIrq", 1'h1, wdtIrq);
		reg_rd(OFS_STATUS, 32'h0000_0005);
		reg_rd(OFS_WDT_CTRL, 32'h0000_0001);
		reg_wr(OFS_WDT_CLEAR, 32'h0000_0000);
		#1 chkb("wdtIrq", 1'h0, wdtIrq);
		repeat (50) @(posedge clk_sys);
		#1 chkb("internalRst", 1'h0, internalRst);
		reg_wr(OFS_WDT_CTRL, 32'h0000_0003);
		n = 0;
		while (internalRst !== 1'h1 && n < 40)
		begin
			@(posedge clk_sys);
			n++;
		end
		chkb("internalRst", 1'h1, internalRst);
		wait_boot();
		expCause = expCause | 32'h0000_0010;
		reg_rd(OFS_CAUSE, expCause);
		$display("test watchdog done");

		@(posedge clk_sys);
		mainOscFail <= 1'h1;
		repeat (8) @(posedge clk_sys);
		mainOscFail <= 1'h0;
		#1 chkb("internalRst", 1'h0, internalRst);
		reg_wr(OFS_OSC_CTRL, 32'h0000_0001);
		reg_rd(OFS_OSC_CTRL, 32'h0000_0001);
		@(posedge clk_sys);
		mainOscFail <= 1'h1;
		lag <= 3'h3;
		repeat (8) @(posedge clk_sys);
		mainOscFail <= 1'h0;
		wait_boot();
		check_boot(NMI_W, 1'h1);
		expCause = expCause | 32'h0000_0020;
		reg_rd(OFS_CAUSE, expCause);
		reg_rd(OFS_STATUS, 32'h0000_0009);
		$display("test oscillator failure done");

		repeat (3) @(posedge clk_sys);
		tally_and_finish();
	end
endmodule
